// ==== fwc_map.svh ====
/*
 * Holds the named constants of the flash write controller: unlock key
 * values, control word field positions, address widths and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef FWC_MAP_SVH
`define FWC_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Unlock key values, in the order software must write them
`define FWC_KEY_FIRST 8'h55
`define FWC_KEY_SECOND 8'hAA
`define FWC_KEY_W 8

////////////////////////////////////////////////////////////////////////////////
// Control word layout
`define FWC_CTL_W 16
`define FWC_CTL_START_BIT 15
`define FWC_CTL_OP_MSB 1
`define FWC_CTL_OP_LSB 0
`define FWC_CTL_RESET 16'h0000

////////////////////////////////////////////////////////////////////////////////
// Target address and source pointer layout
`define FWC_ADDR_LO_W 16
`define FWC_ADDR_HI_W 8
`define FWC_ADDR_W 24
`define FWC_SRC_HALF_W 16
`define FWC_ADDR_LO_RESET 16'h0000
`define FWC_ADDR_HI_RESET 8'h00
`define FWC_SRC_RESET 16'h0000

`endif

// ==== fwc_pkg.sv ====
/*
 * Types shared by the flash write controller: operation codes and the
 * states of the sequencer and of the unlock detector.
 * Assumes nothing of its surroundings.
 */
package fwc_pkg;

    // Operation chosen in the control word
    typedef enum logic [1:0] {
        FWC_OP_PAGE_ERASE = 2'b00,
        FWC_OP_WORD_PROG = 2'b01,
        FWC_OP_ROW_PROG = 2'b10,
        FWC_OP_INACTIVE_ERASE = 2'b11
    } fwc_op_e;

    // Sequencer states
    typedef enum logic [1:0] {
        FWC_ST_IDLE = 2'b00,
        FWC_ST_FETCH = 2'b01,
        FWC_ST_WAIT = 2'b10
    } fwc_state_e;

    // Unlock detector states
    typedef enum logic [1:0] {
        FWC_KS_LOCKED = 2'b00,
        FWC_KS_HALF = 2'b01,
        FWC_KS_ARMED = 2'b10
    } fwc_key_e;

endpackage

// ==== fwc_unlock.sv ====
/*
 * Unlock detector: watches key writes and arms the controller only after
 * the first key value is followed directly by the second.
 * Assumes every register write of the block is visible on its strobes.
 */
`include "fwc_map.svh"

module fwc_unlock (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write strobes
    input wire logic key_wr,
    input wire logic [`FWC_KEY_W-1:0] key_wdata,
    input wire logic other_wr,
    input wire logic consume,
    // Arm state
    output logic armed
);
    import fwc_pkg::*;

    fwc_key_e state;
    fwc_key_e next_state;
    wire logic is_first;
    wire logic is_second;

    // Key value decode
    assign is_first = key_wr && (key_wdata == `FWC_KEY_FIRST);
    assign is_second = key_wr && (key_wdata == `FWC_KEY_SECOND);

    // Next state: any foreign write breaks the sequence
    always_comb begin
        next_state = state;
        case (state)
            FWC_KS_LOCKED: begin
                if (is_first && !other_wr) begin
                    next_state = FWC_KS_HALF;
                end
            end
            FWC_KS_HALF: begin
                if (is_second && !other_wr) begin
                    next_state = FWC_KS_ARMED;
                end else if (is_first && !other_wr) begin
                    next_state = FWC_KS_HALF;
                end else if (key_wr || other_wr || consume) begin
                    next_state = FWC_KS_LOCKED;
                end
            end
            FWC_KS_ARMED: begin
                if (consume || key_wr || other_wr) begin
                    next_state = FWC_KS_LOCKED;
                end
            end
            default: begin
                next_state = FWC_KS_LOCKED;
            end
        endcase
    end

    // State and arm flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= FWC_KS_LOCKED;
            armed <= 1'b0;
        end else begin
            state <= next_state;
            armed <= (next_state == FWC_KS_ARMED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_unlock_order: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(armed) |-> $past(is_second) && $past(state) == FWC_KS_HALF)
        else $error("armed without key pair");

endmodule

// ==== fwc_flash_ctrl.sv ====
/*
 * Flash write controller: holds the control word, target address and row
 * source pointer, checks the unlock sequence and sequences erase and
 * program operations towards the flash array, fetching row data from RAM.
 * Assumes the array answers each command with a one-cycle done pulse, and
 * RAM returns read data one cycle after a read request, on the same clock.
 */
`include "fwc_map.svh"

module fwc_flash_ctrl #(
    parameter int ROW_WORDS = 128,
    parameter int WORD_W = 24,
    parameter int RAM_AW = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register writes from the core
    input wire logic key_wr,
    input wire logic [`FWC_KEY_W-1:0] key_wdata,
    input wire logic ctl_wr,
    input wire logic [`FWC_CTL_W-1:0] ctl_wdata,
    input wire logic addr_lo_wr,
    input wire logic [`FWC_ADDR_LO_W-1:0] addr_lo_wdata,
    input wire logic addr_hi_wr,
    input wire logic [`FWC_ADDR_HI_W-1:0] addr_hi_wdata,
    input wire logic src_lo_wr,
    input wire logic src_hi_wr,
    input wire logic [`FWC_SRC_HALF_W-1:0] src_wdata,
    input wire logic other_wr,
    // Register readback
    output logic [`FWC_CTL_W-1:0] ctl_rdata,
    output logic busy,
    // Flash array side
    output logic flash_cmd_valid,
    output fwc_pkg::fwc_op_e flash_op,
    output logic [`FWC_ADDR_W-1:0] flash_addr,
    output logic flash_wvalid,
    output logic [WORD_W-1:0] flash_wdata,
    input wire logic flash_done,
    // RAM read side
    output logic ram_rd_req,
    output logic [RAM_AW-1:0] ram_addr,
    input wire logic [WORD_W-1:0] ram_rdata
);
    import fwc_pkg::*;

    localparam int CNT_W = $clog2(ROW_WORDS + 1);
    localparam logic [CNT_W-1:0] LAST_IDX = CNT_W'(ROW_WORDS - 1);

    fwc_state_e state;
    logic [`FWC_CTL_W-1:0] flash_op_control;
    logic [`FWC_ADDR_LO_W-1:0] flash_target_addr_low;
    logic [`FWC_ADDR_HI_W-1:0] flash_target_addr_high;
    logic [`FWC_SRC_HALF_W-1:0] src_lo;
    logic [`FWC_SRC_HALF_W-1:0] src_hi;
    logic [CNT_W-1:0] fetch_idx;
    logic rd_pend;
    wire logic armed;
    wire logic start_req;
    wire logic start_ok;
    wire logic wr_blocked;
    wire logic last_fetch;
    wire fwc_op_e req_op;
    wire logic [`FWC_ADDR_W-1:0] effective_target_address;
    wire logic [2*`FWC_SRC_HALF_W-1:0] row_source_pointer;
    wire logic [`FWC_CTL_W-1:0] next_ctl_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Unlock sequence tracking
    fwc_unlock u_unlock (
        .mclk(mclk),
        .rst_n(rst_n),
        .key_wr(key_wr),
        .key_wdata(key_wdata),
        .other_wr(other_wr || addr_lo_wr || addr_hi_wr || src_lo_wr || src_hi_wr),
        .consume(ctl_wr),
        .armed(armed)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request decode
    assign req_op = fwc_op_e'(ctl_wdata[`FWC_CTL_OP_MSB:`FWC_CTL_OP_LSB]);
    assign start_req = ctl_wr && ctl_wdata[`FWC_CTL_START_BIT];
    assign start_ok = start_req && armed && (state == FWC_ST_IDLE);
    assign wr_blocked = (state != FWC_ST_IDLE);
    assign effective_target_address = {flash_target_addr_high, flash_target_addr_low};
    assign row_source_pointer = {src_hi, src_lo};
    assign last_fetch = (fetch_idx == LAST_IDX);
    // Readback shows the chosen operation and the running flag; key never appears
    assign next_ctl_rdata = {busy, flash_op_control[`FWC_CTL_START_BIT-1:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible registers, frozen while an operation runs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flash_op_control <= `FWC_CTL_RESET;
            flash_target_addr_low <= `FWC_ADDR_LO_RESET;
            flash_target_addr_high <= `FWC_ADDR_HI_RESET;
            src_lo <= `FWC_SRC_RESET;
            src_hi <= `FWC_SRC_RESET;
            ctl_rdata <= `FWC_CTL_RESET;
        end else begin
            if (ctl_wr && !wr_blocked) begin
                flash_op_control <= ctl_wdata;
            end
            if (addr_lo_wr && !wr_blocked) begin
                flash_target_addr_low <= addr_lo_wdata;
            end
            if (addr_hi_wr && !wr_blocked) begin
                flash_target_addr_high <= addr_hi_wdata;
            end
            if (src_lo_wr && !wr_blocked) begin
                src_lo <= src_wdata;
            end
            if (src_hi_wr && !wr_blocked) begin
                src_hi <= src_wdata;
            end
            ctl_rdata <= next_ctl_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= FWC_ST_IDLE;
            busy <= 1'b0;
            flash_cmd_valid <= 1'b0;
            flash_op <= FWC_OP_PAGE_ERASE;
            flash_addr <= '0;
            fetch_idx <= '0;
            ram_rd_req <= 1'b0;
            ram_addr <= '0;
        end else begin
            flash_cmd_valid <= 1'b0;
            ram_rd_req <= 1'b0;
            case (state)
                FWC_ST_IDLE: begin
                    if (start_ok) begin
                        flash_cmd_valid <= 1'b1;
                        flash_op <= req_op;
                        flash_addr <= effective_target_address;
                        busy <= 1'b1;
                        fetch_idx <= '0;
                        state <= (req_op == FWC_OP_ROW_PROG) ? FWC_ST_FETCH : FWC_ST_WAIT;
                    end
                end
                FWC_ST_FETCH: begin
                    ram_rd_req <= 1'b1;
                    ram_addr <= RAM_AW'(row_source_pointer + 32'(fetch_idx));
                    fetch_idx <= fetch_idx + 1'b1;
                    if (last_fetch) begin
                        state <= FWC_ST_WAIT;
                    end
                end
                FWC_ST_WAIT: begin
                    if (flash_done && !rd_pend && !ram_rd_req) begin
                        busy <= 1'b0;
                        state <= FWC_ST_IDLE;
                    end
                end
                default: begin
                    state <= FWC_ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Row data forwarding, RAM data one cycle after request
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_pend <= 1'b0;
            flash_wvalid <= 1'b0;
            flash_wdata <= '0;
        end else begin
            rd_pend <= ram_rd_req;
            flash_wvalid <= rd_pend;
            if (rd_pend) begin
                flash_wdata <= ram_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_locked_start_dropped: assert property (
        (start_req && !armed) |=> !flash_cmd_valid && $stable(busy))
        else $error("start taken without unlock");
    a_op_launch: assert property (
        start_ok |=> flash_cmd_valid && busy && flash_op == $past(req_op))
        else $error("operation not launched as chosen");
    a_addr_concat: assert property (
        flash_cmd_valid |-> flash_addr == $past(effective_target_address))
        else $error("target address not concatenated");
    a_addr_fields: assert property (
        flash_cmd_valid |-> flash_addr[`FWC_ADDR_LO_W-1:0] == $past(flash_target_addr_low)
            && flash_addr[`FWC_ADDR_W-1:`FWC_ADDR_LO_W] == $past(flash_target_addr_high))
        else $error("address field misplaced");
    a_erase_no_data: assert property (
        (flash_cmd_valid && flash_op != FWC_OP_ROW_PROG) |-> !ram_rd_req [*3])
        else $error("erase or word op fetched row data");
    a_row_first_fetch: assert property (
        (flash_cmd_valid && flash_op == FWC_OP_ROW_PROG) |=> ram_rd_req
            && ram_addr == RAM_AW'(row_source_pointer))
        else $error("row fetch not at source pointer");
    a_row_data_pass: assert property (
        ram_rd_req |=> ##1 flash_wvalid && flash_wdata == $past(ram_rdata))
        else $error("row data not forwarded");
    a_key_unreadable: assert property (
        (key_wr && !ctl_wr && !busy && !flash_done) |=> ##1 $stable(ctl_rdata))
        else $error("key write visible in readback");

    c_row_done: cover property (
        (flash_cmd_valid && flash_op == FWC_OP_ROW_PROG) ##[1:300] $fell(busy));
    c_page_erase: cover property (flash_cmd_valid && flash_op == FWC_OP_PAGE_ERASE);
    c_locked_start: cover property (start_req && !armed);

endmodule

// ==== testbench.sv ====
/*
 * Self-checking bench for the flash write controller: table of operations,
 * each non-row one also refusing a start while busy, then unlock refusals and reset in mid-run.
 * Assumes fwc_pkg is compiled first and fwc_map.svh is on the include path.
 */
`include "fwc_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import fwc_pkg::*;

    localparam int ROWS = 4;
    logic mclk;
    logic rst_n;
    logic [6:0] stb;
    logic [15:0] wd;
    logic flash_done;
    logic [23:0] ram_rdata;
    logic [15:0] ctl_rdata;
    logic busy;
    logic flash_cmd_valid;
    fwc_op_e flash_op;
    logic [23:0] flash_addr;
    logic flash_wvalid;
    logic [23:0] flash_wdata;
    logic ram_rd_req;
    logic [15:0] ram_addr;
    int errors;
    int total_checks;

    fwc_flash_ctrl #(.ROW_WORDS(ROWS), .WORD_W(24), .RAM_AW(16)) dut (
        .mclk(mclk), .rst_n(rst_n),
        .key_wr(stb[0]), .key_wdata(wd[7:0]), .ctl_wr(stb[1]), .ctl_wdata(wd),
        .addr_lo_wr(stb[2]), .addr_lo_wdata(wd), .addr_hi_wr(stb[3]),
        .addr_hi_wdata(wd[7:0]), .src_lo_wr(stb[4]), .src_hi_wr(stb[5]),
        .src_wdata(wd), .other_wr(stb[6]),
        .ctl_rdata(ctl_rdata), .busy(busy), .flash_cmd_valid(flash_cmd_valid),
        .flash_op(flash_op), .flash_addr(flash_addr), .flash_wvalid(flash_wvalid),
        .flash_wdata(flash_wdata), .flash_done(flash_done),
        .ram_rd_req(ram_rd_req), .ram_addr(ram_addr), .ram_rdata(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and a RAM that answers one cycle after each read
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    function automatic logic [23:0] pat(input logic [15:0] a);
        return {8'hC3, a ^ 16'h5A5A};
    endfunction

    // Unread cycles toggle the data so stale words cannot pass
    always @(posedge mclk) begin
        ram_rdata <= ram_rd_req ? pat(ram_addr) : ~ram_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One-cycle write strobe: 0 key, 1 ctl, 2 lo, 3 hi, 4 src lo, 5 src hi, 6 other
    task automatic wr(input int sel, input logic [15:0] d);
        @(negedge mclk);
        wd = d;
        stb[sel] = 1'b1;
        @(negedge mclk);
        stb = '0;
    endtask

    task automatic wait_cmd(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 4 && !seen; i++) begin
            if (flash_cmd_valid === 1'b1) seen = 1'b1;
            else @(negedge mclk);
        end
    endtask

    task automatic no_cmd(input string msg);
        logic s;
        wait_cmd(s);
        check(s, 0, msg);
        check(busy, 0, msg);
    endtask

    task automatic start(input logic [1:0] op);
        wr(0, 16'h0055);
        wr(0, 16'h00AA);
        wr(1, {1'b1, 13'h0, op});
    endtask

    task automatic run_op(input logic [1:0] op, input logic [7:0] hi, input logic [15:0] lo,
                          input logic [15:0] sh, input logic [15:0] sl);
        logic s;
        int nr;
        int nw;
        nr = 0;
        nw = 0;
        wr(2, lo);
        wr(3, {8'h00, hi});
        wr(5, sh);
        wr(4, sl);
        start(op);
        wait_cmd(s);
        check(s, 1, "no command");
        check(flash_op, op, "op");
        check(flash_addr, {hi, lo}, "address");
        @(negedge mclk);
        check(flash_cmd_valid, 0, "command pulse width");
        check(ctl_rdata[15], 1, "busy readback");
        check(ctl_rdata[1:0], op, "op readback");
        if (op == 2'b10) begin
            for (int i = 0; i < 5 * ROWS + 8; i++) begin
                if (ram_rd_req === 1'b1) begin
                    check(ram_addr, sl + 16'(nr), "ram address");
                    nr++;
                end
                if (flash_wvalid === 1'b1) begin
                    check(flash_wdata, pat(sl + 16'(nw)), "row word");
                    nw++;
                end
                @(negedge mclk);
            end
            check(nr, ROWS, "read count");
            check(nw, ROWS, "word count");
        end else begin
            // A fresh unlock and start while busy must be dropped
            start(2'b01);
            wait_cmd(s);
            check(s, 0, "start while busy");
        end
        flash_done = 1'b1;
        @(negedge mclk);
        flash_done = 1'b0;
        for (int i = 0; i < 3 && busy !== 1'b0; i++) @(negedge mclk);
        check(busy, 0, "busy after done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Operation table: op, high address, low address, source halves
    typedef struct {
        logic [1:0] op;
        logic [7:0] hi;
        logic [15:0] lo;
        logic [15:0] sh;
        logic [15:0] sl;
    } fwc_row_s;

    fwc_row_s rows[4] = '{
        '{2'b00, 8'hA5, 16'h0F00, 16'h0000, 16'h0000},
        '{2'b01, 8'h01, 16'hFFFE, 16'h0000, 16'h0000},
        '{2'b10, 8'h7F, 16'h8100, 16'h0003, 16'h1230},
        '{2'b11, 8'hFF, 16'h0001, 16'h0000, 16'h0000}
    };

    initial begin
        #(50 * 5000);
        errors++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        stb = '0;
        wd = 16'h0000;
        flash_done = 1'b0;
        ram_rdata = 24'h000000;
        errors = 0;
        total_checks = 0;
        repeat (10) @(negedge mclk);
        check({busy, flash_cmd_valid, flash_wvalid, ram_rd_req}, 0, "reset flags");
        check(ctl_rdata, 0, "reset readback");
        check({flash_addr, flash_op}, 0, "reset values");
        rst_n = 1'b1;
        foreach (rows[i]) run_op(rows[i].op, rows[i].hi, rows[i].lo, rows[i].sh, rows[i].sl);
        // Starts not directly preceded by the key pair
        wr(1, 16'h8000);
        no_cmd("start without keys");
        wr(0, 16'h0055);
        wr(6, 16'h0000);
        wr(0, 16'h00AA);
        wr(1, 16'h8001);
        no_cmd("other write between keys");
        wr(0, 16'h00AA);
        wr(0, 16'h0055);
        wr(1, 16'h8002);
        no_cmd("keys reversed");
        wr(0, 16'h0055);
        wr(0, 16'h00AA);
        wr(2, 16'h1234);
        wr(1, 16'h8003);
        no_cmd("write after keys");
        wr(0, 16'h0055);
        wr(1, 16'h0000);
        wr(0, 16'h00AA);
        wr(1, 16'h8000);
        no_cmd("control write between keys");
        // Reset in mid-operation clears state and the unlock
        start(2'b00);
        @(negedge mclk);
        check(busy, 1, "busy before reset");
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        check({busy, flash_cmd_valid}, 0, "mid-run reset");
        check(ctl_rdata, 0, "mid-run readback");
        check(flash_addr, 0, "mid-run address");
        rst_n = 1'b1;
        wr(1, 16'h8000);
        no_cmd("start after reset");
        run_op(2'b10, 8'h00, 16'h0040, 16'h0000, 16'hFFF0);
        stop_test();
    end
endmodule
